/* hdl/stage_ctrl_regs.svh */
`ifndef STAGE_CTRL_REGS_SVH
`define STAGE_CTRL_REGS_SVH
// Register selector codes, equal to the low five bits of the read/write instruction
`define SEL_SOURCE_LOW 5'h12
`define SEL_SOURCE_HIGH 5'h13
`define SEL_STATE_LOW 5'h14
`define SEL_STATE_HIGH 5'h15
`define SEL_STATE_EXTRA 5'h16
// Reset values
`define RST_SOURCE_LOW 8'h80
`define RST_SOURCE_HIGH 8'h00
`define RST_STATE_LOW 8'hff
`define RST_STATE_HIGH 8'hff
`define RST_STATE_EXTRA 2'h3
// Field positions in the extra state register
`define EXTRA_USED_MSB 1
`define EXTRA_FILL 6'h3f
// Channel counts and special stage indices (zero based)
`define NUM_STAGES 18
`define NUM_MUXED 16
`define STAGE8_IDX 7
`define SYNC_DEPTH 3
`endif

/* hdl/stage_ctrl_pkg.sv */
package stage_ctrl_pkg;
  // Source of control that a stage currently follows
  typedef enum logic [1:0] {
    SRC_OFF,
    SRC_SERIAL,
    SRC_PARALLEL,
    SRC_FAST_BUS
  } stage_src_t;
  typedef logic [7:0] reg_byte_t;
endpackage

/* hdl/pin_sync.sv */
`timescale 1ns/100ps
// Three-stage synchroniser per bit; output changes once stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Raw and filtered levels
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] rst_val,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;

  // A zero-width instance would leave the parent's pins unsynchronised
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs a width of at least one");
  end

  // Only the second stage reads the first one
  assign nxt_out = (s2_ff ~^ s3_ff) & s2_ff | ~(s2_ff ~^ s3_ff) & out_ff;
  assign sync_out = out_ff;

  // Synchronous reset loads a constant-like strap fed from a tie-off in the parent
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_ff <= rst_val;
      s2_ff <= rst_val;
      s3_ff <= rst_val;
      out_ff <= rst_val;
    end else begin
      meta_ff <= async_in;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end
endmodule // pin_sync

/* hdl/stage_ctrl_regs_top.sv */
`timescale 1ns/100ps
`include "stage_ctrl_regs.svh"
module stage_ctrl_regs_top
#(
  parameter int STAGES = `NUM_STAGES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Decoded register access from the serial frame logic
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_sel,
  input wire stage_ctrl_pkg::reg_byte_t reg_wdata,
  output stage_ctrl_pkg::reg_byte_t reg_rdata,
  output logic reg_rvalid,
  // Control context
  input wire logic fast_bus_select,
  input wire logic [15:0] fast_bus_state_bit,
  input wire logic supply_ok_output,
  input wire logic reset_pin_n,
  // Parallel input pins, stage 1 to 16, asynchronous
  input wire logic [15:0] parallel_input_pin,
  // Per-stage results, 1 on power_output means stage switched on, 1 in stage_serial_state_bit means off
  output logic [STAGES-1:0] power_output,
  output logic [STAGES-1:0] stage_source_select_bit,
  output logic [STAGES-1:0] stage_serial_state_bit
);
  import stage_ctrl_pkg::*;

  // Elaboration checks; the concatenations below assume 16 muxed and 2 serial-only stages
  if (STAGES != `NUM_STAGES) begin : g_bad_stages
    $error("stage_ctrl_regs_top supports 18 stages only");
  end
  if (`NUM_MUXED + 2 != `NUM_STAGES) begin : g_bad_split
    $error("muxed and serial-only stage counts do not add up");
  end
  if (`STAGE8_IDX >= `NUM_MUXED) begin : g_bad_stage8
    $error("stage 8 index lies outside the muxed stages");
  end

  reg_byte_t src_low_ff;
  reg_byte_t src_high_ff;
  reg_byte_t state_low_ff;
  reg_byte_t state_high_ff;
  logic [`EXTRA_USED_MSB:0] state_extra_ff;
  reg_byte_t rdata_ff;
  logic rvalid_ff;
  logic [STAGES-1:0] out_ff;
  logic [STAGES-1:0] nxt_out;
  reg_byte_t nxt_rdata;
  logic [15:0] pin_sync_lvl;
  logic [15:0] pin_rst;
  logic [1:0] enable_sync;
  logic wr_src_low;
  logic wr_src_high;
  logic wr_state_low;
  logic wr_state_high;
  logic wr_state_extra;
  logic [15:0] mux_bits;
  logic [STAGES-1:0] serial_bits;
  logic global_on;

  // Inputs from pins go through three stages; idle level high means off, except stage 8 where low means off
  assign pin_rst = 16'hff7f;
  pin_sync #(.WIDTH(16)) u_pin_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(parallel_input_pin),
    .rst_val(pin_rst),
    .sync_out(pin_sync_lvl)
  );

  // Supply-ok and reset pin are asynchronous as well; start in the off state
  pin_sync #(.WIDTH(2)) u_enable_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in({supply_ok_output, reset_pin_n}),
    .rst_val(2'h0),
    .sync_out(enable_sync)
  );

  // Write strobes per register
  assign wr_src_low = reg_wr && (reg_sel == `SEL_SOURCE_LOW);
  assign wr_src_high = reg_wr && (reg_sel == `SEL_SOURCE_HIGH);
  assign wr_state_low = reg_wr && (reg_sel == `SEL_STATE_LOW);
  assign wr_state_high = reg_wr && (reg_sel == `SEL_STATE_HIGH);
  assign wr_state_extra = reg_wr && (reg_sel == `SEL_STATE_EXTRA);

  // Source select for stages 1 to 8; stage 8 starts on its external source
  always_ff @(posedge core_clk) begin
    if (srst) begin
      src_low_ff <= `RST_SOURCE_LOW;
    end else if (wr_src_low) begin
      src_low_ff <= reg_wdata;
    end
  end

  // Source select for stages 9 to 16; all start under serial control
  always_ff @(posedge core_clk) begin
    if (srst) begin
      src_high_ff <= `RST_SOURCE_HIGH;
    end else if (wr_src_high) begin
      src_high_ff <= reg_wdata;
    end
  end

  // Serial state for stages 1 to 8; reset value keeps them off
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_low_ff <= `RST_STATE_LOW;
    end else if (wr_state_low) begin
      state_low_ff <= reg_wdata;
    end
  end

  // Serial state for stages 9 to 16
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_high_ff <= `RST_STATE_HIGH;
    end else if (wr_state_high) begin
      state_high_ff <= reg_wdata;
    end
  end

  // Stages 17 and 18; only two bits are kept, so the upper bits leave no state behind
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_extra_ff <= `RST_STATE_EXTRA;
    end else if (wr_state_extra) begin
      state_extra_ff <= reg_wdata[`EXTRA_USED_MSB:0];
    end
  end

  // Read selection; unknown selectors answer zero
  assign nxt_rdata =
    (reg_sel == `SEL_SOURCE_LOW) ? src_low_ff :
    (reg_sel == `SEL_SOURCE_HIGH) ? src_high_ff :
    (reg_sel == `SEL_STATE_LOW) ? state_low_ff :
    (reg_sel == `SEL_STATE_HIGH) ? state_high_ff :
    (reg_sel == `SEL_STATE_EXTRA) ? {`EXTRA_FILL, state_extra_ff} :
    8'h00;

  // Read answer: captured only on a read, then it stands until the next one
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Read strobe echo, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
    end
  end

  // Stages 17 and 18 have no select bit and are always serial
  assign mux_bits = {src_high_ff, src_low_ff};
  assign serial_bits = {state_extra_ff, state_high_ff, state_low_ff};
  assign global_on = enable_sync[1] & enable_sync[0];

  // Per-stage output decision: first name the source a stage follows, then pick its level
  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_stage
      stage_src_t src_kind;
      logic par_on;
      logic fast_on;
      if (g >= `NUM_MUXED) begin : g_serial_only
        // No pin, no select bit and no fast-bus bit exist for these stages
        assign src_kind = global_on ? SRC_SERIAL : SRC_OFF;
        assign par_on = 1'b0;
        assign fast_on = 1'b0;
      end else begin : g_muxed
        assign src_kind = !global_on ? SRC_OFF :
          !mux_bits[g] ? SRC_SERIAL :
          fast_bus_select ? SRC_PARALLEL : SRC_FAST_BUS;
        if (g == `STAGE8_IDX) begin : g_s8
          // Stage 8 is high-active on its pin and stays off under the fast bus
          assign par_on = pin_sync_lvl[g];
          assign fast_on = 1'b0;
        end else begin : g_sn
          assign par_on = ~pin_sync_lvl[g];
          assign fast_on = ~fast_bus_state_bit[g];
        end
      end
      // Off is the fallback, so an unexpected source can never switch a stage on
      assign nxt_out[g] =
        (src_kind == SRC_SERIAL) ? ~serial_bits[g] :
        (src_kind == SRC_PARALLEL) ? par_on :
        (src_kind == SRC_FAST_BUS) ? fast_on :
        1'b0;
    end
  endgenerate

  // Outputs are registered; a glitch-free gate drive was preferred to one cycle of latency
  always_ff @(posedge core_clk) begin
    if (srst) out_ff <= '0;
    else out_ff <= nxt_out;
  end

  assign power_output = out_ff;
  assign stage_source_select_bit = {2'h0, mux_bits};
  assign stage_serial_state_bit = serial_bits;
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
endmodule // stage_ctrl_regs_top

/* tb/host_model.sv */
`timescale 1ns/100ps
module host_model
  import stage_ctrl_pkg::*;
(
  // Clock in, register strobes out
  input wire logic core_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [4:0] reg_sel,
  output reg_byte_t reg_wdata
);
  // Idle strobes from time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = 5'h00;
    reg_wdata = 8'h00;
  end
  // One request per call; released data shows the inverse so a stale byte never looks valid
  task automatic xfer(input logic w, input logic [4:0] s, input reg_byte_t d);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_wdata <= ~d;
  endtask
endmodule // host_model

/* tb/stage_ctrl_regs_sva.sv */
`timescale 1ns/100ps
module stage_ctrl_regs_sva
  import stage_ctrl_pkg::*;
#(
  parameter int STAGES = 18
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_sel,
  input wire reg_byte_t reg_wdata,
  input wire reg_byte_t reg_rdata,
  input wire logic reg_rvalid,
  // Enables and stage results
  input wire logic supply_ok_output,
  input wire logic reset_pin_n,
  input wire logic [STAGES-1:0] power_output,
  input wire logic [STAGES-1:0] stage_source_select_bit,
  input wire logic [STAGES-1:0] stage_serial_state_bit
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Read handshake
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  extra_fill_a: assert property (reg_rd && reg_sel == 5'h16 |=> reg_rdata[7:2] == 6'h3f)
    else $error("fill bits not one");
  // Stored bits follow writes
  src_wr_a: assert property (reg_wr && reg_sel == 5'h12 |=>
    stage_source_select_bit[7:0] == $past(reg_wdata)) else $error("select low not stored");
  state_wr_a: assert property (reg_wr && reg_sel == 5'h15 |=>
    stage_serial_state_bit[15:8] == $past(reg_wdata)) else $error("state high not stored");
  extra_wr_a: assert property (reg_wr && reg_sel == 5'h16 |=>
    stage_serial_state_bit[17:16] == $past(reg_wdata[1:0])) else $error("extra not stored");
  serial_only_a: assert property (stage_source_select_bit[17:16] == 2'h0)
    else $error("stages 17 18 not serial");
  // Gating; six cycles covers the enable synchroniser
  supply_off_a: assert property (!supply_ok_output [*6] |-> power_output == '0)
    else $error("output on without supply");
  pin_off_a: assert property (!reset_pin_n [*6] |-> power_output == '0)
    else $error("output on in pin reset");
  serial_follow_a: assert property ((supply_ok_output && reset_pin_n) [*6] |->
    power_output[17] == !$past(stage_serial_state_bit[17])) else $error("stage 18 wrong");
  cover property (reg_rd && reg_sel == 5'h16);
  cover property (reg_wr && reg_sel == 5'h12);
  cover property (power_output[17]);
endmodule // stage_ctrl_regs_sva

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import stage_ctrl_pkg::*;
  logic core_clk = 0, srst = 1, fast_bus_select = 1, supply_ok_output = 0, reset_pin_n = 0;
  logic [15:0] fast_bus_state_bit = 0, parallel_input_pin = 0;
  logic reg_wr, reg_rd, reg_rvalid;
  logic [4:0] reg_sel;
  reg_byte_t reg_wdata, reg_rdata;
  logic [17:0] power_output, stage_source_select_bit, stage_serial_state_bit;
  int fails = 0, checks = 0;
  always #10 core_clk = ~core_clk;
  host_model host (
    .core_clk(core_clk),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_sel(reg_sel),
    .reg_wdata(reg_wdata)
  );
  stage_ctrl_regs_top uut (
    .core_clk(core_clk),
    .srst(srst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_sel(reg_sel),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .fast_bus_select(fast_bus_select),
    .fast_bus_state_bit(fast_bus_state_bit),
    .supply_ok_output(supply_ok_output),
    .reset_pin_n(reset_pin_n),
    .parallel_input_pin(parallel_input_pin),
    .power_output(power_output),
    .stage_source_select_bit(stage_source_select_bit),
    .stage_serial_state_bit(stage_serial_state_bit)
  );
  task check(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read: wait for the answer strobe at a rising edge and take the byte at that edge
  task rd(input logic [4:0] s, input reg_byte_t e);
    int n;
    n = 0;
    host.xfer(1'b0, s, 8'h00);
    do begin
      @(posedge core_clk);
      n++;
    end while (reg_rvalid !== 1'b1 && n < 4);
    if (reg_rvalid !== 1'b1) begin
      fails++;
      final_report;
    end else begin
      check(18'(reg_rdata), 18'(e));
    end
  endtask
  task final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Expected stage levels; stage 8 has no fast-bus bit and stays off under the fast bus
  function logic [17:0] exp_out(input logic [15:0] src, input logic [17:0] st);
    for (int i = 0; i < 18; i++)
      exp_out[i] = (i > 15 || !src[i]) ? !st[i] : fast_bus_select ?
        ((i == 7) ? parallel_input_pin[i] : !parallel_input_pin[i]) :
        ((i == 7) ? 1'b0 : !fast_bus_state_bit[i]);
    if (!supply_ok_output || !reset_pin_n) exp_out = '0;
  endfunction
  // Ten cycles of reset, then every register and stage result must show its reset value
  task reset_test;
    srst <= 1'b1;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    rd(5'h12, 8'h80);
    rd(5'h13, 8'h00);
    rd(5'h14, 8'hff);
    rd(5'h15, 8'hff);
    rd(5'h16, 8'hff);
    rd(5'h1f, 8'h00);
    check(stage_source_select_bit, 18'h00080);
    check(stage_serial_state_bit, 18'h3ffff);
    check(power_output, 18'h00000);
    $display("reset values done");
  endtask
  // Hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    final_report;
  end
  initial begin
    reg_byte_t v[5];
    logic [15:0] src;
    void'($urandom(84491));
    reset_test;
    // Write all five, then read back, so a crossed decode shows
    repeat (4) begin
      for (int i = 0; i < 5; i++) v[i] = 8'($urandom);
      for (int i = 0; i < 5; i++) host.xfer(1'b1, 5'(5'h12 + i), v[i]);
      // Let the last write settle before looking at the stored bits
      @(posedge core_clk);
      check(stage_source_select_bit, {2'h0, v[1], v[0]});
      check(stage_serial_state_bit, {v[4][1:0], v[3], v[2]});
      for (int i = 0; i < 5; i++) rd(5'(5'h12 + i), (i == 4) ? {6'h3f, v[4][1:0]} : v[i]);
    end
    $display("read back done");
    // Registers now hold random bytes, so a second reset shows all of them return
    reset_test;
    // Modes: serial, parallel, fast bus, supply low, reset pin low, random mix
    for (int m = 0; m < 6; m++) begin
      src = (m == 5) ? 16'($urandom) : (m == 1 || m == 2) ? 16'hffff : 16'h0000;
      v[0] = src[7:0];
      v[1] = src[15:8];
      for (int i = 2; i < 5; i++) v[i] = 8'($urandom);
      for (int i = 0; i < 5; i++) host.xfer(1'b1, 5'(5'h12 + i), v[i]);
      fast_bus_select <= (m == 5) ? 1'($urandom) : (m != 2);
      supply_ok_output <= (m != 3);
      reset_pin_n <= (m != 4);
      parallel_input_pin <= 16'($urandom);
      fast_bus_state_bit <= 16'($urandom);
      repeat (8) @(posedge core_clk);
      check(power_output, exp_out(src, {v[4][1:0], v[3], v[2]}));
    end
    $display("output modes done");
    final_report;
  end
endmodule // tb_top
bind stage_ctrl_regs_top stage_ctrl_regs_sva #(.STAGES(STAGES)) chk (
  .core_clk(core_clk),
  .srst(srst),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_sel(reg_sel),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .supply_ok_output(supply_ok_output),
  .reset_pin_n(reset_pin_n),
  .power_output(power_output),
  .stage_source_select_bit(stage_source_select_bit),
  .stage_serial_state_bit(stage_serial_state_bit)
);
